// *** pkg/pcs_pkg.sv ***
// constants shared by the transceiver control and status register bank
package pcs_pkg;
	// ==========================================
	// bus shape
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 10;
	localparam int REG_W = 16;
	localparam int IRQ_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================
	// register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SLEEP_ABORT = 10'h01b;
	localparam logic [IDX_W-1:0] IDX_CABLE_TEST = 10'h01e;
	localparam logic [IDX_W-1:0] IDX_RESET_STBY = 10'h01f;
	localparam logic [IDX_W-1:0] IDX_FRAME_CTRL = 10'h040;
	localparam logic [IDX_W-1:0] IDX_FRAME_PAT = 10'h041;
	localparam logic [IDX_W-1:0] IDX_LINK_STAT = 10'h133;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h200;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h201;
	// ==========================================
	// field positions
	localparam int B_PIN_ABORT_EN = 1;
	localparam int B_LOC_ABORT = 0;
	localparam int B_TDR_START = 15;
	localparam int B_TDR_AUTO = 14;
	localparam int B_TDR_DONE = 1;
	localparam int B_TDR_FAIL = 0;
	localparam int B_GLOBAL_RST = 15;
	localparam int B_RESTART = 14;
	localparam int B_STANDBY = 7;
	localparam int B_FRAME_EN = 0;
	localparam int B_LINK_CS = 14;
	localparam int B_SEND_STATE = 13;
	localparam int B_LINK_UP = 12;
	localparam int B_DESCR_LOCK = 2;
	localparam int B_LOC_RCVR = 1;
	localparam int B_REM_RCVR = 0;
	localparam int IRQ_TDR_DONE = 0;
	localparam int IRQ_TDR_FAIL = 1;
	localparam int IRQ_LINK_DOWN = 2;
	localparam int IRQ_SLEEP_ABORT = 3;
	// ==========================================
	// reset values and masks
	localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
	localparam logic [REG_W-1:0] RST_FRAME_PAT = 16'h88f7;
	localparam logic [REG_W-1:0] LINK_MASK = 16'h7007;
endpackage

// *** pkg/pcs_regbus_if.sv ***
// internal register access strobes between bus port and register bank
`timescale 1ns/10ps
interface pcs_regbus_if;
	logic wr_en;
	logic [pcs_pkg::IDX_W-1:0] wr_idx;
	logic [pcs_pkg::DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [pcs_pkg::IDX_W-1:0] rd_idx;
	logic [pcs_pkg::DATA_W-1:0] rd_data;
	logic rd_ok;
	modport port (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
		input wr_ok, rd_data, rd_ok);
	modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
		output wr_ok, rd_data, rd_ok);
endinterface

// *** logic/pcs_edge_det.sv ***
// edge detector for synchronous status inputs, edges decoded combinationally against a registered sample
`timescale 1ns/10ps
module pcs_edge_det #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic rst,
	// level in, edges out
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] prev_r;

	always_ff @(posedge aclk) begin
		if (rst) begin
			prev_r <= '0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;
endmodule

// *** logic/pcs_axil_port.sv ***
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/10ps
module pcs_axil_port (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [pcs_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pcs_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [pcs_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [pcs_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	pcs_regbus_if.port bus
);
	logic aw_held_r;
	logic w_held_r;
	logic ar_held_r;
	logic [pcs_pkg::IDX_W-1:0] aw_idx_r;
	logic [pcs_pkg::IDX_W-1:0] ar_idx_r;
	logic [pcs_pkg::DATA_W-1:0] wdata_r;
	logic [3:0] wstrb_r;

	// ready flags are kept as flops of their own so every AXI output is registered
	assign bus.wr_en = aw_held_r && w_held_r && !bvalid;
	assign bus.wr_idx = aw_idx_r;
	assign bus.wr_data = wdata_r;
	assign bus.wr_strb = wstrb_r;
	assign bus.rd_en = ar_held_r && !rvalid;
	assign bus.rd_idx = ar_idx_r;

	// ==========================================
	// write path: address and data may come in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			aw_idx_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid <= 1'b0;
			bresp <= pcs_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				awready <= 1'b0;
				aw_idx_r <= awaddr[pcs_pkg::ADDR_W-1:2];
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wready <= 1'b0;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (bus.wr_en) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
				bvalid <= 1'b1;
				bresp <= bus.wr_ok ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_held_r <= 1'b0;
			arready <= 1'b1;
			ar_idx_r <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= pcs_pkg::RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				ar_held_r <= 1'b1;
				arready <= 1'b0;
				ar_idx_r <= araddr[pcs_pkg::ADDR_W-1:2];
			end
			if (bus.rd_en) begin
				ar_held_r <= 1'b0;
				rvalid <= 1'b1;
				rdata <= bus.rd_data;
				rresp <= bus.rd_ok ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

// *** logic/pcs_regs.sv ***
// control and status register bank of the single-pair transceiver
// Notes on behaviour
// - with the pin abort enable set, an indicator pin used as an LED may end sleep talks.
// - the local abort bit makes the device drop sleep talks while in sleep acknowledge.
// - writing one to the cable test trigger starts a run and completion clears it.
// - with auto run set, a link drop launches a cable test run by itself.
// - read-only done flag at bit 1 and fail flag at bit 0 report the run result.
// - writing one to the global soft reset resets logic and registers, then clears itself.
// - writing one to the restart bit restarts the circuitry, keeps registers, then clears.
// - the standby bit set puts the device in standby, clear means normal operation.
// - a 16-bit frame type pattern resets to 88F7 and is matched when its enable is set.
// - the link status word is read-only, resets to zero, flags at 14, 13, 12, 2, 1, 0.
// - bit 12 mirrors the link monitor, bit 13 shows the control machine sending data.
// - bit 2 reads one while the descrambler is locked.
// - bit 1 shows local receiver link valid, bit 0 remote receiver link valid.
`timescale 1ns/10ps
module pcs_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [pcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pcs_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [pcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pcs_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sleep negotiation
	input wire logic in_sleep_ack,
	input wire logic clock_or_indicator_pin,
	input wire logic indicator_is_led,
	output logic sleep_abort,
	// cable reflectometry engine
	input wire logic tdr_done_in,
	input wire logic tdr_fail_in,
	output logic tdr_start,
	// resets and modes
	output logic global_reset,
	output logic logic_restart,
	output logic standby,
	// frame type detector
	output logic [pcs_pkg::REG_W-1:0] frame_pattern,
	output logic frame_match_en,
	// link status sources
	input wire logic link_up_cs_in,
	input wire logic control_in_send_state,
	input wire logic link_status_in,
	input wire logic descr_lock_in,
	input wire logic loc_rcvr_ok_in,
	input wire logic rem_rcvr_ok_in,
	// interrupt
	output logic irq
);
	pcs_regbus_if bus ();

	logic reg_rst;
	logic lo_lane;
	logic hi_lane;
	logic wr_abort;
	logic wr_cable;
	logic wr_rststby;
	logic wr_fctl;
	logic wr_pat;
	logic wr_istat;
	logic wr_imask;
	logic pin_abort_en_r;
	logic loc_abort_r;
	logic tdr_auto_r;
	logic tdr_done_r;
	logic tdr_fail_r;
	logic [pcs_pkg::REG_W-1:0] link_word_r;
	logic [pcs_pkg::REG_W-1:0] link_word_nxt;
	logic [pcs_pkg::IRQ_W-1:0] irq_stat_r;
	logic [pcs_pkg::IRQ_W-1:0] irq_mask_r;
	logic [pcs_pkg::IRQ_W-1:0] irq_event;
	logic [2:0] rises;
	logic [2:0] falls;
	logic tdr_set;
	logic tdr_clr;
	logic abort_nxt;
	logic [pcs_pkg::REG_W-1:0] wmask;
	logic [pcs_pkg::REG_W-1:0] rd_word;

	// ==========================================
	// bus front end and edge detection
	pcs_axil_port u_port (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.bus(bus)
	);

	pcs_edge_det #(.W(3)) u_edges (
		.aclk(aclk),
		.rst(reg_rst),
		.level({link_status_in, tdr_fail_in, tdr_done_in}),
		.rise(rises),
		.fall(falls)
	);

	// soft global reset hits everything the pin does, except the global bit itself and the bus port so
	// the write that caused it still gets its response
	assign reg_rst = !aresetn || global_reset;

	// ==========================================
	// write decode
	assign lo_lane = bus.wr_strb[0];
	assign hi_lane = bus.wr_strb[1];
	assign wmask = {{8{hi_lane}}, {8{lo_lane}}};
	assign wr_abort = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_SLEEP_ABORT;
	assign wr_cable = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_CABLE_TEST;
	assign wr_rststby = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_RESET_STBY;
	assign wr_fctl = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_FRAME_CTRL;
	assign wr_pat = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_FRAME_PAT;
	assign wr_istat = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_IRQ_STAT;
	assign wr_imask = bus.wr_en && bus.wr_idx == pcs_pkg::IDX_IRQ_MASK;

	always_comb begin
		case (bus.wr_idx)
			pcs_pkg::IDX_SLEEP_ABORT, pcs_pkg::IDX_CABLE_TEST,
			pcs_pkg::IDX_RESET_STBY, pcs_pkg::IDX_FRAME_CTRL,
			pcs_pkg::IDX_FRAME_PAT, pcs_pkg::IDX_LINK_STAT,
			pcs_pkg::IDX_IRQ_STAT, pcs_pkg::IDX_IRQ_MASK: bus.wr_ok = 1'b1;
			default: bus.wr_ok = 1'b0;
		endcase
	end

	// ==========================================
	// sleep abort controls
	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			pin_abort_en_r <= 1'b0;
			loc_abort_r <= 1'b0;
		end else if (wr_abort && lo_lane) begin
			pin_abort_en_r <= bus.wr_data[pcs_pkg::B_PIN_ABORT_EN];
			loc_abort_r <= bus.wr_data[pcs_pkg::B_LOC_ABORT];
		end
	end

	assign abort_nxt = in_sleep_ack && (loc_abort_r
		|| (pin_abort_en_r && indicator_is_led && clock_or_indicator_pin));

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			sleep_abort <= 1'b0;
		end else begin
			sleep_abort <= abort_nxt;
		end
	end

	// ==========================================
	// cable reflectometry control and result
	assign tdr_set = (wr_cable && hi_lane && bus.wr_data[pcs_pkg::B_TDR_START])
		|| (tdr_auto_r && falls[2]);
	assign tdr_clr = rises[0];

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			tdr_start <= 1'b0;
		end else if (tdr_set) begin
			tdr_start <= 1'b1;
		end else if (tdr_clr) begin
			tdr_start <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			tdr_auto_r <= 1'b0;
		end else if (wr_cable && hi_lane) begin
			tdr_auto_r <= bus.wr_data[pcs_pkg::B_TDR_AUTO];
		end
	end

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			tdr_done_r <= 1'b0;
			tdr_fail_r <= 1'b0;
		end else begin
			tdr_done_r <= tdr_done_in;
			tdr_fail_r <= tdr_fail_in;
		end
	end

	// ==========================================
	// resets and standby
	// the global bit is kept out of its own reset effect, only the pin resets it, and it clears itself after one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_reset <= 1'b0;
		end else begin
			global_reset <= !global_reset && wr_rststby && hi_lane
				&& bus.wr_data[pcs_pkg::B_GLOBAL_RST];
		end
	end

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			logic_restart <= 1'b0;
			standby <= 1'b0;
		end else begin
			logic_restart <= wr_rststby && hi_lane && bus.wr_data[pcs_pkg::B_RESTART];
			if (wr_rststby && lo_lane) begin
				standby <= bus.wr_data[pcs_pkg::B_STANDBY];
			end
		end
	end

	// ==========================================
	// frame type pattern and enable
	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			frame_pattern <= pcs_pkg::RST_FRAME_PAT;
			frame_match_en <= 1'b0;
		end else begin
			if (wr_pat) begin
				frame_pattern <= (bus.wr_data[pcs_pkg::REG_W-1:0] & wmask)
					| (frame_pattern & ~wmask);
			end
			if (wr_fctl && lo_lane) begin
				frame_match_en <= bus.wr_data[pcs_pkg::B_FRAME_EN];
			end
		end
	end

	// ==========================================
	// link status word, writes have no effect
	always_comb begin
		link_word_nxt = pcs_pkg::RST_ZERO;
		link_word_nxt[pcs_pkg::B_LINK_CS] = link_up_cs_in;
		link_word_nxt[pcs_pkg::B_SEND_STATE] = control_in_send_state;
		link_word_nxt[pcs_pkg::B_LINK_UP] = link_status_in;
		link_word_nxt[pcs_pkg::B_DESCR_LOCK] = descr_lock_in;
		link_word_nxt[pcs_pkg::B_LOC_RCVR] = loc_rcvr_ok_in;
		link_word_nxt[pcs_pkg::B_REM_RCVR] = rem_rcvr_ok_in;
	end

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			link_word_r <= pcs_pkg::RST_ZERO;
		end else begin
			link_word_r <= link_word_nxt;
		end
	end

	// ==========================================
	// interrupts: sticky status, set wins over a write-one clear
	assign irq_event[pcs_pkg::IRQ_TDR_DONE] = rises[0];
	assign irq_event[pcs_pkg::IRQ_TDR_FAIL] = rises[1];
	assign irq_event[pcs_pkg::IRQ_LINK_DOWN] = falls[2];
	assign irq_event[pcs_pkg::IRQ_SLEEP_ABORT] = abort_nxt && !sleep_abort;

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			irq_stat_r <= '0;
		end else if (wr_istat && lo_lane) begin
			irq_stat_r <= (irq_stat_r & ~bus.wr_data[pcs_pkg::IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_r <= irq_stat_r | irq_event;
		end
	end

	always_ff @(posedge aclk) begin
		if (reg_rst) begin
			irq_mask_r <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_imask && lo_lane) begin
				irq_mask_r <= bus.wr_data[pcs_pkg::IRQ_W-1:0];
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ==========================================
	// read mux, reserved bits read zero
	always_comb begin
		rd_word = pcs_pkg::RST_ZERO;
		bus.rd_ok = 1'b1;
		case (bus.rd_idx)
			pcs_pkg::IDX_SLEEP_ABORT: begin
				rd_word[pcs_pkg::B_PIN_ABORT_EN] = pin_abort_en_r;
				rd_word[pcs_pkg::B_LOC_ABORT] = loc_abort_r;
			end
			pcs_pkg::IDX_CABLE_TEST: begin
				rd_word[pcs_pkg::B_TDR_START] = tdr_start;
				rd_word[pcs_pkg::B_TDR_AUTO] = tdr_auto_r;
				rd_word[pcs_pkg::B_TDR_DONE] = tdr_done_r;
				rd_word[pcs_pkg::B_TDR_FAIL] = tdr_fail_r;
			end
			pcs_pkg::IDX_RESET_STBY: begin
				rd_word[pcs_pkg::B_STANDBY] = standby;
			end
			pcs_pkg::IDX_FRAME_CTRL: begin
				rd_word[pcs_pkg::B_FRAME_EN] = frame_match_en;
			end
			pcs_pkg::IDX_FRAME_PAT: rd_word = frame_pattern;
			pcs_pkg::IDX_LINK_STAT: rd_word = link_word_r;
			pcs_pkg::IDX_IRQ_STAT: rd_word[pcs_pkg::IRQ_W-1:0] = irq_stat_r;
			pcs_pkg::IDX_IRQ_MASK: rd_word[pcs_pkg::IRQ_W-1:0] = irq_mask_r;
			default: bus.rd_ok = 1'b0;
		endcase
	end

	assign bus.rd_data = {16'h0000, rd_word};

	// ==========================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	pin_abort_gate_a: assert property ((!pin_abort_en_r && !loc_abort_r && !global_reset)
		|=> !sleep_abort) else $error("pin abort passed while disabled");
	pin_abort_path_a: assert property ((pin_abort_en_r && indicator_is_led && in_sleep_ack
		&& clock_or_indicator_pin && !global_reset) |=> sleep_abort)
		else $error("enabled pin abort did not reach sleep abort");
	local_abort_a: assert property ((in_sleep_ack && loc_abort_r && !global_reset)
		|=> sleep_abort) else $error("local abort ignored in sleep acknowledge");
	tdr_clear_a: assert property ((tdr_start && tdr_clr && !tdr_set && !global_reset)
		|=> !tdr_start) else $error("trigger not cleared on completion");
	tdr_manual_a: assert property ((wr_cable && hi_lane && bus.wr_data[pcs_pkg::B_TDR_START]
		&& !global_reset) |=> tdr_start) else $error("write one did not start run");
	auto_run_a: assert property ((tdr_auto_r && $fell(link_status_in) && !global_reset)
		|=> tdr_start) else $error("link drop did not launch run");
	no_auto_a: assert property ((!tdr_auto_r && !tdr_start && !wr_cable && !global_reset)
		|=> !tdr_start) else $error("run started without trigger");
	done_read_a: assert property ((tdr_done_in && !global_reset) ##1 bus.rd_en
		&& bus.rd_idx == pcs_pkg::IDX_CABLE_TEST |-> bus.rd_data[pcs_pkg::B_TDR_DONE])
		else $error("done flag not visible");
	global_reset_a: assert property (global_reset |=> !global_reset
		&& frame_pattern == pcs_pkg::RST_FRAME_PAT && !standby && !tdr_auto_r)
		else $error("soft global reset incomplete");
	restart_keep_a: assert property ((logic_restart && !bus.wr_en && !global_reset)
		|=> !logic_restart && $stable(frame_pattern) && $stable(standby))
		else $error("restart disturbed registers or stuck");
	standby_set_a: assert property ((wr_rststby && lo_lane && !global_reset)
		|=> standby == $past(bus.wr_data[pcs_pkg::B_STANDBY]))
		else $error("standby bit not taken");
	link_reserved_a: assert property ((link_word_r & ~pcs_pkg::LINK_MASK) == pcs_pkg::RST_ZERO)
		else $error("reserved link status bit set");
	link_mirror_a: assert property (!global_reset |=> link_word_r[pcs_pkg::B_LINK_UP]
		== $past(link_status_in) && link_word_r[pcs_pkg::B_DESCR_LOCK]
		== $past(descr_lock_in) && link_word_r[pcs_pkg::B_LOC_RCVR]
		== $past(loc_rcvr_ok_in)) else $error("link status word not mirroring");
	reserved_read_a: assert property ((bus.rd_en && bus.rd_idx == pcs_pkg::IDX_RESET_STBY)
		|-> bus.rd_data == {16'h0000, 8'h00, standby, 7'h00})
		else $error("reserved control bits read nonzero");
	irq_level_a: assert property (!global_reset ##1 !global_reset
		|-> irq == |($past(irq_stat_r) & $past(irq_mask_r)))
		else $error("interrupt level wrong");
endmodule

// *** dv/pcs_regs_tb.sv ***
// self-checking bench for the transceiver control and status register bank
`timescale 1ns/10ps
module pcs_regs_tb;
	// ==========================================
	// signals
	logic aclk = 0;
	logic aresetn = 0;
	logic [11:0] s_axi_awaddr = 0;
	logic [11:0] s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0;
	logic s_axi_wvalid = 0;
	logic s_axi_bready = 0;
	logic s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic in_sleep_ack = 0;
	logic clock_or_indicator_pin = 0;
	logic indicator_is_led = 0;
	logic tdr_done_in = 0;
	logic tdr_fail_in = 0;
	logic sleep_abort, tdr_start, global_reset, logic_restart, standby, frame_match_en, irq;
	logic [15:0] frame_pattern;
	// link inputs packed low to high: remote, local, descrambler, link, send, c and s
	logic [5:0] lk = 0;
	logic [31:0] rv;
	logic [1:0] rs;
	int fail_count = 0;
	int n_checks = 0;
	int gr_n = 0;
	int lr_n = 0;
	int lp[6] = '{0, 1, 2, 12, 13, 14};
	logic [9:0] ri[6] = '{10'h01b, 10'h01e, 10'h01f, 10'h040, 10'h041, 10'h133};
	logic [15:0] rx[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h88f7, 16'h0000};
	// {ack, abort bits, led, pin, expected}
	logic [5:0] sa[7] = '{6'h08, 6'h29, 6'h22, 6'h32, 6'h37, 6'h34, 6'h26};
	logic link_up_cs_in, control_in_send_state, link_status_in;
	logic descr_lock_in, loc_rcvr_ok_in, rem_rcvr_ok_in;
	assign {link_up_cs_in, control_in_send_state, link_status_in} = lk[5:3];
	assign {descr_lock_in, loc_rcvr_ok_in, rem_rcvr_ok_in} = lk[2:0];

	pcs_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_sleep_ack,
		.clock_or_indicator_pin, .indicator_is_led, .sleep_abort, .tdr_done_in,
		.tdr_fail_in, .tdr_start, .global_reset, .logic_restart, .standby, .frame_pattern,
		.frame_match_en, .link_up_cs_in, .control_in_send_state, .link_status_in,
		.descr_lock_in, .loc_rcvr_ok_in, .rem_rcvr_ok_in, .irq);

	initial begin
		forever #4 aclk = ~aclk;
	end

	// pulses last one cycle, so count them rather than poll
	always @(posedge aclk) begin
		if (global_reset === 1'b1) gr_n++;
		if (logic_restart === 1'b1) lr_n++;
	end

	// ==========================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic tmo(input int k);
		if (k >= 64) begin
			fail_count++;
			$display("CHECK FAILED bus answer expected 1 seen 0");
			conclude();
		end
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0;
				rs = s_axi_bresp;
				break;
			end
		end
		tmo(k);
	endtask

	task automatic rd(input logic [9:0] i);
		int k;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				rv = s_axi_rdata;
				rs = s_axi_rresp;
				break;
			end
		end
		tmo(k);
	endtask

	task automatic idle();
		repeat (3) @(posedge aclk);
	endtask

	// ==========================================
	// tests
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		foreach (ri[j]) begin
			rd(ri[j]);
			chk("reset value", rv, {16'h0000, rx[j]});
		end
		rd(10'h3ff);
		chk("unmapped resp", rs, pcs_pkg::RESP_SLVERR);
		wr(10'h3ff, 32'h0000_0000);
		chk("unmapped write resp", rs, pcs_pkg::RESP_SLVERR);
		$display("test reset done");
		foreach (sa[j]) begin
			wr(10'h01b, {30'h0, sa[j][4:3]});
			in_sleep_ack <= sa[j][5];
			indicator_is_led <= sa[j][2];
			clock_or_indicator_pin <= sa[j][1];
			idle();
			chk("sleep abort", sleep_abort, sa[j][0]);
		end
		wr(10'h01b, 32'hffff_ffff);
		rd(10'h01b);
		chk("abort reserved", rv, 32'h0000_0003);
		wr(10'h01b, 32'h0000_0000);
		$display("test sleep abort done");
		wr(10'h01e, 32'h0000_8000);
		rd(10'h01e);
		chk("trigger", rv, 32'h0000_8000);
		wr(10'h01e, 32'h0000_0000);
		chk("trigger kept", tdr_start, 1);
		tdr_fail_in <= 1;
		tdr_done_in <= 1;
		idle();
		chk("trigger clear", tdr_start, 0);
		rd(10'h01e);
		chk("run flags", rv, 32'h0000_0003);
		tdr_done_in <= 0;
		tdr_fail_in <= 0;
		lk <= 6'h08;
		wr(10'h01e, 32'h0000_4000);
		lk <= 6'h00;
		idle();
		chk("auto run", tdr_start, 1);
		tdr_done_in <= 1;
		wr(10'h01e, 32'h0000_0000);
		tdr_done_in <= 0;
		lk <= 6'h08;
		idle();
		lk <= 6'h00;
		idle();
		chk("manual only", tdr_start, 0);
		$display("test cable run done");
		foreach (lp[j]) begin
			lk <= 6'h01 << j;
			idle();
			rd(10'h133);
			chk("link word", rv, 32'h0000_0001 << lp[j]);
		end
		lk <= 6'h3f;
		wr(10'h133, 32'hffff_ffff);
		rd(10'h133);
		chk("link word all", rv, 32'h0000_7007);
		$display("test link word done");
		rd(10'h200);
		chk("irq status", rv, 32'h0000_000f);
		chk("irq masked", irq, 0);
		wr(10'h201, 32'h0000_0001);
		idle();
		chk("irq raised", irq, 1);
		wr(10'h200, 32'h0000_0001);
		idle();
		chk("irq cleared", irq, 0);
		rd(10'h200);
		chk("irq left", rv, 32'h0000_000e);
		$display("test irq done");
		wr(10'h01f, 32'h0000_0080);
		wr(10'h041, 32'h0000_1234);
		wr(10'h040, 32'h0000_0001);
		idle();
		chk("standby", standby, 1);
		chk("pattern", frame_pattern, 32'h0000_1234);
		chk("match enable", frame_match_en, 1);
		wr(10'h01f, 32'h0000_4080);
		rd(10'h01f);
		chk("restart self clear", rv, 32'h0000_0080);
		chk("restart pulse", lr_n, 1);
		chk("pattern kept", frame_pattern, 32'h0000_1234);
		// standby written as one with the reset, so only the reset can clear it
		wr(10'h01f, 32'h0000_8080);
		rd(10'h041);
		chk("pattern reset", rv, 32'h0000_88f7);
		chk("global pulse", gr_n, 1);
		chk("standby reset", standby, 0);
		rd(10'h01f);
		chk("global self clear", rv, 32'h0000_0000);
		$display("test resets done");
		conclude();
	end
endmodule
